// file: bench/cdl_top_bench.sv
`timescale 1ns/100ps
module cdl_top_bench;
   import cdl_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] awa = '0;
   logic [11:0] ara = '0;
   logic [31:0] wd = '0;
   logic [3:0] ws = '0;
   logic awv = 1'b0, wv = 1'b0, arv = 1'b0, ph = 1'b0, le = 1'b0;
   // Ready held high: legal, and no re-raise races between back-to-back calls
   logic bry = 1'b1, rry = 1'b1;
   logic awr, wrr, bv, arr, rv;
   logic [1:0] br, rr;
   logic [31:0] rd;
   wire logic [9:0] pins;
   logic [9:0] amt;
   logic [5:0] code;
   int fails = 0;
   int compares = 0;
   always #5 clk = ~clk;
   cdl_top i_dut (.CLK_IN(clk), .RST_IN(rst), .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv),
      .AXI_AWREADY_OUT(awr), .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(ws), .AXI_WVALID_IN(wv),
      .AXI_WREADY_OUT(wrr), .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(bry),
      .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr), .AXI_RDATA_OUT(rd),
      .AXI_RRESP_OUT(rr), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rry), .LOOP_PHASE_ABOVE_IN(ph),
      .LOOP_ERR_IN(le), .SYNTH_REF_INPUT_POWERDOWN_OUT(pins[9]), .HYSTERESIS_ENABLE_OUT(pins[8]),
      .RISING_EDGE_SELECT_OUT(pins[7]), .HYSTERESIS_AMOUNT_OUT(amt),
      .DELAY_LOOP_POWERDOWN_OUT(pins[6]), .DIGITAL_CLOCK_POWERDOWN_OUT(pins[5]),
      .FINE_LINE_DUTY_CORRECT_EN_OUT(pins[4]), .FINE_LINE_CROSS_CTRL_EN_OUT(pins[3]),
      .COARSE_LINE_DUTY_CORRECT_EN_OUT(pins[2]), .COARSE_LINE_CROSS_CTRL_EN_OUT(pins[1]),
      .DELAY_CODE_OUT(code), .LOOP_LOCK_FLAG_OUT(pins[0]));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // Handshakes judged at the falling edge, where the rising-edge view is settled
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
      input logic [1:0] er);
      logic ta, tw, got;
      got = 1'b0;
      awa <= {2'b00, idx, 2'b00};
      wd <= {24'h0, d};
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      // No cycle count assumed; only the watchdog ends a hung wait
      while (!got)
      begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wrr;
         got = bv;
         if (got) chk({30'h0, br}, {30'h0, er});
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
      chk({31'h0, got}, 32'h1);
   endtask : wr
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
      logic ta, got;
      got = 1'b0;
      ara <= {2'b00, idx, 2'b00};
      arv <= 1'b1;
      while (!got)
      begin
         @(negedge clk);
         ta = arv & arr;
         got = rv;
         if (got) chk(rd, {24'h0, exp});
         if (got) chk({30'h0, rr}, {30'h0, er});
         @(posedge clk);
         if (ta) arv <= 1'b0;
      end
      chk({31'h0, got}, 32'h1);
   endtask : rdc
   task automatic pc(input logic [9:0] p, input logic [9:0] a);
      @(negedge clk);
      chk({22'h0, pins}, {22'h0, p});
      chk({22'h0, amt}, {22'h0, a});
      @(posedge clk);
   endtask : pc
   task automatic t_reset;
      rdc(IDX_REF_PD, 8'h00, RESP_OKAY);
      rdc(IDX_SYSREF_HI, 8'h00, RESP_OKAY);
      rdc(IDX_SYSREF_LO, 8'h00, RESP_OKAY);
      rdc(IDX_LOOP_PWR, 8'h1f, RESP_OKAY);
      rdc(IDX_LOOP_CTRL, 8'hf0, RESP_OKAY);
      rdc(IDX_LOOP_STAT, 8'h00, RESP_OKAY);
      pc(10'h07e, 10'h000);
   endtask : t_reset
   task automatic t_sysref;
      wr(IDX_SYSREF_HI, 8'hff, 4'h1, RESP_OKAY);
      rdc(IDX_SYSREF_HI, 8'h0f, RESP_OKAY);
      wr(IDX_SYSREF_LO, 8'ha5, 4'h1, RESP_OKAY);
      pc(10'h1fe, 10'h3a5);
      wr(IDX_SYSREF_HI, 8'h0a, 4'h1, RESP_OKAY);
      pc(10'h17e, 10'h2a5);
      // Strobe low: accepted but nothing lands
      wr(IDX_SYSREF_LO, 8'h00, 4'h0, RESP_OKAY);
      rdc(IDX_SYSREF_LO, 8'ha5, RESP_OKAY);
      wr(IDX_SYSREF_HI, 8'h04, 4'h1, RESP_OKAY);
      pc(10'h0fe, 10'h000);
      wr(IDX_REF_PD, 8'hff, 4'h1, RESP_OKAY);
      rdc(IDX_REF_PD, 8'h01, RESP_OKAY);
      pc(10'h2fe, 10'h000);
      wr(IDX_REF_PD, 8'h00, 4'h1, RESP_OKAY);
      pc(10'h0fe, 10'h000);
   endtask : t_sysref
   task automatic t_power;
      wr(IDX_LOOP_PWR, 8'h0a, 4'h1, RESP_OKAY);
      pc(10'h08a, 10'h000);
      wr(IDX_LOOP_PWR, 8'hf5, 4'h1, RESP_OKAY);
      rdc(IDX_LOOP_PWR, 8'h15, RESP_OKAY);
      pc(10'h0f4, 10'h000);
      wr(8'h85, 8'h01, 4'h1, RESP_SLVERR);
      rdc(8'h85, 8'h00, RESP_SLVERR);
      rdc(IDX_REF_PD, 8'h00, RESP_OKAY);
   endtask : t_power
   task automatic t_loop;
      wr(IDX_LOOP_CTRL, 8'h47, 4'h1, RESP_OKAY);
      rdc(IDX_LOOP_CTRL, 8'h47, RESP_OKAY);
      wr(IDX_LOOP_PWR, 8'h1e, 4'h1, RESP_OKAY);
      wr(IDX_LOOP_CTRL, 8'hf1, 4'h1, RESP_OKAY);
      repeat (20) @(posedge clk);
      ph <= 1'b1;
      for (int n = 0; n < 300 && pins[0] !== 1'b1; n++) @(negedge clk);
      chk({31'h0, pins[0]}, 32'h1);
      @(posedge clk);
      rdc(IDX_LOOP_STAT, 8'h01, RESP_OKAY);
      wr(IDX_LOOP_CTRL, 8'hf0, 4'h1, RESP_OKAY);
      @(negedge clk);
      chk({26'h0, code}, 32'h20);
      @(posedge clk);
   endtask : t_loop
   // Slope 0 lock, track error both ways, lost clear, search stop, search-only hold
   task automatic t_err;
      logic [5:0] c;
      wr(IDX_LOOP_CTRL, 8'h11, 4'h1, RESP_OKAY);
      ph <= 1'b0;
      repeat (8) @(posedge clk);
      pc(10'h09f, 10'h000);
      le <= 1'b1;
      repeat (8) @(posedge clk);
      pc(10'h09f, 10'h000);
      wr(IDX_LOOP_CTRL, 8'h91, 4'h1, RESP_OKAY);
      le <= 1'b0;
      repeat (8) @(posedge clk);
      le <= 1'b1;
      repeat (8) @(posedge clk);
      rdc(IDX_LOOP_STAT, 8'h02, RESP_OKAY);
      wr(IDX_LOOP_STAT, 8'h02, 4'h1, RESP_OKAY);
      rdc(IDX_LOOP_STAT, 8'h00, RESP_OKAY);
      le <= 1'b0;
      repeat (8) @(posedge clk);
      le <= 1'b1;
      repeat (8) @(posedge clk);
      rdc(IDX_LOOP_STAT, 8'h04, RESP_OKAY);
      wr(IDX_LOOP_CTRL, 8'h2c, 4'h1, RESP_OKAY);
      wr(IDX_LOOP_CTRL, 8'h2d, 4'h1, RESP_OKAY);
      ph <= 1'b1;
      repeat (8) @(posedge clk);
      pc(10'h09f, 10'h000);
      @(negedge clk);
      c = code;
      chk({31'h0, c > 6'h20}, 32'h1);
      repeat (8) @(negedge clk);
      chk({26'h0, code}, {26'h0, c});
   endtask : t_err
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      summarize();
   end
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_sysref();
      t_power();
      t_loop();
      t_err();
      summarize();
   end
endmodule : cdl_top_bench

// file: core/cdl_loop_ctrl.sv
`timescale 1ns/100ps
module cdl_loop_ctrl #(
   parameter int CODE_W = 6,
   parameter logic [CODE_W-1:0] INIT_CODE = 6'h20,
   parameter int STEP_CYCLES = cdl_pkg::LOOP_STEP_CYCLES
) (
   input wire logic clk_in, // System clock
   input wire logic rst_in, // Synchronous reset
   cdl_loop_if.ctrl lp // Config in, status out
);
   import cdl_pkg::*;
   typedef struct packed {
      cdl_loop_state_t st;
      logic [CODE_W-1:0] code;
      logic [7:0] cnt;
      logic phase_prev;
      logic err_prev;
      logic down_done;
      logic locked;
      logic failed;
      logic lost_evt;
   } cdl_ctrl_state_t;
   cdl_ctrl_state_t q, n;
   logic tick, hit, err_rise, up, range_end;

   always_comb
   begin
      n = q;
      n.lost_evt = 1'b0;
      n.phase_prev = lp.phase_above;
      n.err_prev = lp.err;
      tick = (q.cnt == 8'h00);
      n.cnt = tick ? 8'(STEP_CYCLES - 1) : q.cnt - 8'h01;
      hit = lp.slope ? (!q.phase_prev && lp.phase_above)
         : (q.phase_prev && !lp.phase_above);
      err_rise = lp.err && !q.err_prev;
      up = (lp.dir == DIR_UP) || (lp.dir == DIR_BOTH && q.down_done);
      range_end = 1'b0;
      if (!lp.run)
      begin
         n.st = LOOP_IDLE;
         n.code = INIT_CODE;
         n.locked = 1'b0;
         n.failed = 1'b0;
      end
      else
      begin
         case (q.st)
            LOOP_IDLE:
            begin
               n.st = LOOP_SEARCH;
               n.code = INIT_CODE;
               n.down_done = 1'b0;
            end
            LOOP_SEARCH:
            begin
               if (!err_rise && hit)
               begin
                  n.locked = 1'b1;
                  n.st = (lp.mode == MODE_SEARCH_ONLY) ? LOOP_HOLD : LOOP_TRACK;
               end
               else if (!err_rise && tick)
               begin
                  if (up && q.code == {CODE_W{1'b1}})
                     range_end = 1'b1;
                  else if (up)
                     n.code = q.code + 1'b1;
                  else if (q.code != '0)
                     n.code = q.code - 1'b1;
                  else if (lp.dir == DIR_BOTH && !q.down_done)
                  begin
                     n.down_done = 1'b1;
                     n.code = INIT_CODE;
                  end
                  else
                     range_end = 1'b1;
               end
               // Running off the range counts as a search error
               if (err_rise || range_end)
               begin
                  if (lp.search_retry)
                  begin
                     n.code = INIT_CODE;
                     n.down_done = 1'b0;
                  end
                  else
                  begin
                     n.st = LOOP_FAILED;
                     n.failed = 1'b1;
                  end
               end
            end
            LOOP_TRACK:
            begin
               if (err_rise && lp.track_restart)
               begin
                  n.st = LOOP_SEARCH;
                  n.code = INIT_CODE;
                  n.down_done = 1'b0;
                  n.locked = 1'b0;
                  n.lost_evt = 1'b1;
               end
               else if (tick)
               begin
                  if (lp.phase_above == lp.slope && q.code != '0)
                     n.code = q.code - 1'b1;
                  else if (lp.phase_above != lp.slope && q.code != {CODE_W{1'b1}})
                     n.code = q.code + 1'b1;
               end
            end
            LOOP_HOLD: n.st = LOOP_HOLD;
            LOOP_FAILED: n.failed = 1'b1;
            default: n.st = LOOP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         q <= '0;
         q.st <= LOOP_IDLE;
         q.code <= INIT_CODE;
      end
      else
         q <= n;
   end

   assign lp.code = q.code;
   assign lp.locked = q.locked;
   assign lp.failed = q.failed;
   assign lp.lost_evt = q.lost_evt;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_search_err;
      lp.run && q.st == LOOP_SEARCH ##0 err_rise;
   endsequence
   AST_SEARCH_STOP: assert property (s_search_err ##0 !lp.search_retry |=> q.st == LOOP_FAILED
      ##1 (lp.failed || !lp.run)) else $error("search error did not stop");
   AST_TRACK_CONT: assert property (lp.run && q.st == LOOP_TRACK && err_rise && !lp.track_restart
      |=> q.st == LOOP_TRACK && !lp.lost_evt) else $error("track error not ignored");
   AST_DIR_DOWN: assert property (lp.run && q.st == LOOP_SEARCH && lp.dir == DIR_DOWN && tick
      && !hit && !err_rise && q.code != '0 |=> q.code == $past(q.code) - 1'b1)
      else $error("downward search step wrong");
   AST_MODE: assert property (lp.run && q.st == LOOP_SEARCH && hit && !err_rise
      |=> lp.locked && (q.st == LOOP_HOLD) == ($past(lp.mode) == MODE_SEARCH_ONLY))
      else $error("mode after lock wrong");
   AST_SLOPE: assert property (lp.run && q.st == LOOP_SEARCH && !lp.slope && !err_rise
      && $fell(lp.phase_above) |=> lp.locked) else $error("negative slope not locked");
endmodule : cdl_loop_ctrl

// file: core/cdl_loop_if.sv
`timescale 1ns/100ps
interface cdl_loop_if #(parameter int CODE_W = 6);
   logic run;
   logic slope;
   logic track_restart;
   logic search_retry;
   logic [1:0] dir;
   logic [1:0] mode;
   logic phase_above;
   logic err;
   logic [CODE_W-1:0] code;
   logic locked;
   logic failed;
   logic lost_evt;
   modport ctrl(input run, slope, track_restart, search_retry, dir, mode, phase_above, err,
      output code, locked, failed, lost_evt);
   modport host(output run, slope, track_restart, search_retry, dir, mode, phase_above, err,
      input code, locked, failed, lost_evt);
endinterface : cdl_loop_if

// file: core/cdl_pkg.sv
package cdl_pkg;
   // Register indexes; byte address is four times the index
   localparam logic [7:0] IDX_REF_PD = 8'h84;
   localparam logic [7:0] IDX_SYSREF_HI = 8'h88;
   localparam logic [7:0] IDX_SYSREF_LO = 8'h89;
   localparam logic [7:0] IDX_LOOP_PWR = 8'h90;
   localparam logic [7:0] IDX_LOOP_CTRL = 8'h91;
   localparam logic [7:0] IDX_LOOP_STAT = 8'h92;
   // Field positions
   localparam int BIT_REF_PD = 0;
   localparam int BIT_HYS_EN = 3;
   localparam int BIT_RISE = 2;
   localparam int BIT_FINE_DC = 4;
   localparam int BIT_FINE_XC = 3;
   localparam int BIT_COARSE_DC = 2;
   localparam int BIT_COARSE_XC = 1;
   localparam int BIT_LOOP_PD = 0;
   localparam int BIT_TRACK_ERR = 7;
   localparam int BIT_SEARCH_ERR = 6;
   localparam int BIT_SLOPE = 5;
   localparam int SEARCH_LSB = 3;
   localparam int MODE_LSB = 1;
   localparam int BIT_CTRL_EN = 0;
   localparam int BIT_ST_LOCK = 0;
   localparam int BIT_ST_LOST = 1;
   localparam int BIT_ST_FAIL = 2;
   // Reset values and writable masks
   localparam logic [7:0] RST_REF_PD = 8'h00;
   localparam logic [7:0] RST_SYSREF_HI = 8'h00;
   localparam logic [7:0] RST_SYSREF_LO = 8'h00;
   localparam logic [7:0] RST_LOOP_PWR = 8'h1f;
   localparam logic [7:0] RST_LOOP_CTRL = 8'hf0;
   localparam logic [7:0] MASK_REF_PD = 8'h01;
   localparam logic [7:0] MASK_SYSREF_HI = 8'h0f;
   localparam logic [7:0] MASK_LOOP_PWR = 8'h1f;
   // Codes
   localparam logic [1:0] DIR_DOWN = 2'h0;
   localparam logic [1:0] DIR_UP = 2'h1;
   localparam logic [1:0] DIR_BOTH = 2'h2;
   localparam logic [1:0] MODE_SEARCH_ONLY = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int HYS_STEP_MV = 10;
   localparam int LOOP_STEP_CYCLES = 4;
   typedef enum logic [2:0] {LOOP_IDLE, LOOP_SEARCH, LOOP_TRACK, LOOP_HOLD, LOOP_FAILED}
      cdl_loop_state_t;
endpackage : cdl_pkg

// file: core/cdl_top.sv
`timescale 1ns/100ps
// Contract
// - Reference input of the frequency multiplier powered down while its bit is 1.
// - Hysteresis applies only while enable bit 3 is set; resets to 0.
// - Edge-select bit 2 picks rising-edge sampling of SYSREF; resets to 0.
// - Ten-bit hysteresis code from two registers, 10 mV per set bit.
// - Loop power-down bit 0 holds loop and clock generator off; resets to 1.
// - Duty correction on fine line bit 4, coarse line bit 2; reset 1.
// - Cross control on fine line bit 3, coarse line bit 1; reset 1.
// - Track error: bit 7 at 0 continues, at 1 restarts; reset 1.
// - Search error: bit 6 at 0 stops, at 1 retries; reset 1.
// - Search direction field: 00 down, 01 up, 10 both; reset 10.
// - Controller enable 0 holds static delay; 1 runs feedback loop; reset 0.
// - Status flags locked, lost, failed; all reset to 0.
module cdl_top
   import cdl_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int CODE_W = 6,
   parameter logic [CODE_W-1:0] STATIC_CODE = 6'h20,
   parameter logic [CODE_W-1:0] INIT_CODE = 6'h20
) (
   input wire logic CLK_IN, // 100 MHz clock
   input wire logic RST_IN, // Synchronous reset, high
   input wire logic [ADDR_W-1:0] AXI_AWADDR_IN, // Write address
   input wire logic AXI_AWVALID_IN, // Write address valid
   output logic AXI_AWREADY_OUT, // Write address ready
   input wire logic [31:0] AXI_WDATA_IN, // Write data
   input wire logic [3:0] AXI_WSTRB_IN, // Write strobes
   input wire logic AXI_WVALID_IN, // Write data valid
   output logic AXI_WREADY_OUT, // Write data ready
   output logic [1:0] AXI_BRESP_OUT, // Write response
   output logic AXI_BVALID_OUT, // Write response valid
   input wire logic AXI_BREADY_IN, // Write response ready
   input wire logic [ADDR_W-1:0] AXI_ARADDR_IN, // Read address
   input wire logic AXI_ARVALID_IN, // Read address valid
   output logic AXI_ARREADY_OUT, // Read address ready
   output logic [31:0] AXI_RDATA_OUT, // Read data
   output logic [1:0] AXI_RRESP_OUT, // Read response
   output logic AXI_RVALID_OUT, // Read data valid
   input wire logic AXI_RREADY_IN, // Read data ready
   input wire logic LOOP_PHASE_ABOVE_IN, // Phase detector pin, async
   input wire logic LOOP_ERR_IN, // Loop error pin, async
   output logic SYNTH_REF_INPUT_POWERDOWN_OUT, // Multiplier reference off
   output logic HYSTERESIS_ENABLE_OUT, // SYSREF hysteresis on
   output logic RISING_EDGE_SELECT_OUT, // SYSREF rising-edge sampling
   output logic [9:0] HYSTERESIS_AMOUNT_OUT, // Hysteresis code, 10 mV per bit
   output logic DELAY_LOOP_POWERDOWN_OUT, // Delay loop off
   output logic DIGITAL_CLOCK_POWERDOWN_OUT, // Digital clock generator off
   output logic FINE_LINE_DUTY_CORRECT_EN_OUT, // Fine line duty correction
   output logic FINE_LINE_CROSS_CTRL_EN_OUT, // Fine line cross control
   output logic COARSE_LINE_DUTY_CORRECT_EN_OUT, // Coarse line duty correction
   output logic COARSE_LINE_CROSS_CTRL_EN_OUT, // Coarse line cross control
   output logic [CODE_W-1:0] DELAY_CODE_OUT, // Delay line setting
   output logic LOOP_LOCK_FLAG_OUT // Loop locked
);
   import cdl_pkg::*;

   typedef struct packed {
      logic ph1, ph2, ph3, ph;
      logic er1, er2, er3, er;
      logic [7:0] synth_ref_pd;
      logic [7:0] sysref_receiver_ctrl_high;
      logic [7:0] sysref_hysteresis_low;
      logic [7:0] delay_loop_power;
      logic [7:0] delay_loop_control;
      logic lost;
      logic aw_got;
      logic [ADDR_W-1:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic wlane0;
      logic awready, wready, bvalid, arready, rvalid;
      logic [1:0] bresp, rresp;
      logic [31:0] rdata;
      logic ref_pd, hys_en, rise;
      logic [9:0] hys_amt;
      logic loop_pd, fine_dc, fine_xc, coarse_dc, coarse_xc;
      logic [CODE_W-1:0] code;
      logic lock;
   } cdl_top_state_t;

   cdl_top_state_t q, next_q;
   cdl_loop_if #(.CODE_W(CODE_W)) lp();
   logic commit;
   logic wr_ok;
   logic [7:0] widx;
   logic rd_hit;
   logic [7:0] rd_byte;

   cdl_loop_ctrl #(
      .CODE_W(CODE_W),
      .INIT_CODE(INIT_CODE),
      .STEP_CYCLES(LOOP_STEP_CYCLES)
   ) u_ctrl (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .lp(lp.ctrl)
   );

   // Controller runs only when powered and enabled
   assign lp.run = !q.delay_loop_power[BIT_LOOP_PD]
      && q.delay_loop_control[BIT_CTRL_EN];
   assign lp.slope = q.delay_loop_control[BIT_SLOPE];
   assign lp.track_restart = q.delay_loop_control[BIT_TRACK_ERR];
   assign lp.search_retry = q.delay_loop_control[BIT_SEARCH_ERR];
   assign lp.dir = q.delay_loop_control[SEARCH_LSB +: 2];
   assign lp.mode = q.delay_loop_control[MODE_LSB +: 2];
   assign lp.phase_above = q.ph;
   assign lp.err = q.er;

   // Unmapped index or upper address bits set gives an error answer
   function automatic logic idx_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = a[9:2];
      idx_mapped = (a[ADDR_W-1:10] == '0) && (i == IDX_REF_PD || i == IDX_SYSREF_HI
         || i == IDX_SYSREF_LO || i == IDX_LOOP_PWR || i == IDX_LOOP_CTRL
         || i == IDX_LOOP_STAT);
   endfunction : idx_mapped

   always_comb
   begin
      next_q = q;
      // Three-stage pin synchronisers, change taken when stages two and three agree
      next_q.ph1 = LOOP_PHASE_ABOVE_IN;
      next_q.ph2 = q.ph1;
      next_q.ph3 = q.ph2;
      if (q.ph2 == q.ph3)
         next_q.ph = q.ph3;
      next_q.er1 = LOOP_ERR_IN;
      next_q.er2 = q.er1;
      next_q.er3 = q.er2;
      if (q.er2 == q.er3)
         next_q.er = q.er3;

      // Write channel: address and data accepted in either order
      if (AXI_AWVALID_IN && q.awready)
      begin
         next_q.aw_got = 1'b1;
         next_q.awaddr = AXI_AWADDR_IN;
      end
      if (AXI_WVALID_IN && q.wready)
      begin
         next_q.w_got = 1'b1;
         next_q.wdata = AXI_WDATA_IN;
         next_q.wlane0 = AXI_WSTRB_IN[0];
      end
      if (q.bvalid && AXI_BREADY_IN)
         next_q.bvalid = 1'b0;

      commit = q.aw_got && q.w_got && !q.bvalid;
      widx = q.awaddr[9:2];
      wr_ok = commit && idx_mapped(q.awaddr);
      if (commit)
      begin
         next_q.aw_got = 1'b0;
         next_q.w_got = 1'b0;
         next_q.bvalid = 1'b1;
         next_q.bresp = idx_mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      end
      // Only byte lane 0 carries register bits; other lanes are ignored
      if (wr_ok && q.wlane0)
      begin
         case (widx)
            IDX_REF_PD: next_q.synth_ref_pd = q.wdata[7:0] & MASK_REF_PD;
            IDX_SYSREF_HI: next_q.sysref_receiver_ctrl_high = q.wdata[7:0] & MASK_SYSREF_HI;
            IDX_SYSREF_LO: next_q.sysref_hysteresis_low = q.wdata[7:0];
            IDX_LOOP_PWR: next_q.delay_loop_power = q.wdata[7:0] & MASK_LOOP_PWR;
            IDX_LOOP_CTRL: next_q.delay_loop_control = q.wdata[7:0];
            default: next_q.lost = q.lost;
         endcase
      end
      // Lost flag: write one to clear, a new loss in the same cycle wins
      if (wr_ok && q.wlane0 && widx == IDX_LOOP_STAT && q.wdata[BIT_ST_LOST])
         next_q.lost = 1'b0;
      if (lp.lost_evt)
         next_q.lost = 1'b1;
      next_q.awready = !next_q.aw_got && !next_q.bvalid;
      next_q.wready = !next_q.w_got && !next_q.bvalid;

      // Read channel
      rd_hit = idx_mapped(AXI_ARADDR_IN);
      case (AXI_ARADDR_IN[9:2])
         IDX_REF_PD: rd_byte = q.synth_ref_pd;
         IDX_SYSREF_HI: rd_byte = q.sysref_receiver_ctrl_high;
         IDX_SYSREF_LO: rd_byte = q.sysref_hysteresis_low;
         IDX_LOOP_PWR: rd_byte = q.delay_loop_power;
         IDX_LOOP_CTRL: rd_byte = q.delay_loop_control;
         IDX_LOOP_STAT: rd_byte = {5'h00, lp.failed, q.lost, lp.locked};
         default: rd_byte = 8'h00;
      endcase
      if (q.rvalid && AXI_RREADY_IN)
         next_q.rvalid = 1'b0;
      if (AXI_ARVALID_IN && q.arready)
      begin
         next_q.rvalid = 1'b1;
         next_q.rdata = rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
         next_q.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      next_q.arready = !next_q.rvalid;

      // Output flops
      next_q.ref_pd = q.synth_ref_pd[BIT_REF_PD];
      next_q.hys_en = q.sysref_receiver_ctrl_high[BIT_HYS_EN];
      next_q.rise = q.sysref_receiver_ctrl_high[BIT_RISE];
      // Code forced to zero so the receiver sees no hysteresis while disabled
      next_q.hys_amt = q.sysref_receiver_ctrl_high[BIT_HYS_EN]
         ? {q.sysref_receiver_ctrl_high[1:0], q.sysref_hysteresis_low} : 10'h000;
      next_q.loop_pd = q.delay_loop_power[BIT_LOOP_PD];
      next_q.fine_dc = q.delay_loop_power[BIT_FINE_DC];
      next_q.coarse_dc = q.delay_loop_power[BIT_COARSE_DC];
      next_q.fine_xc = q.delay_loop_power[BIT_FINE_XC];
      next_q.coarse_xc = q.delay_loop_power[BIT_COARSE_XC];
      next_q.code = lp.run ? lp.code : STATIC_CODE;
      next_q.lock = lp.locked;
   end

   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         q <= '0;
         q.synth_ref_pd <= RST_REF_PD;
         q.sysref_receiver_ctrl_high <= RST_SYSREF_HI;
         q.sysref_hysteresis_low <= RST_SYSREF_LO;
         q.delay_loop_power <= RST_LOOP_PWR;
         q.delay_loop_control <= RST_LOOP_CTRL;
         q.loop_pd <= 1'b1;
         q.fine_dc <= 1'b1;
         q.fine_xc <= 1'b1;
         q.coarse_dc <= 1'b1;
         q.coarse_xc <= 1'b1;
         q.code <= STATIC_CODE;
      end
      else
         q <= next_q;
   end

   assign AXI_AWREADY_OUT = q.awready;
   assign AXI_WREADY_OUT = q.wready;
   assign AXI_BRESP_OUT = q.bresp;
   assign AXI_BVALID_OUT = q.bvalid;
   assign AXI_ARREADY_OUT = q.arready;
   assign AXI_RDATA_OUT = q.rdata;
   assign AXI_RRESP_OUT = q.rresp;
   assign AXI_RVALID_OUT = q.rvalid;
   assign SYNTH_REF_INPUT_POWERDOWN_OUT = q.ref_pd;
   assign HYSTERESIS_ENABLE_OUT = q.hys_en;
   assign RISING_EDGE_SELECT_OUT = q.rise;
   assign HYSTERESIS_AMOUNT_OUT = q.hys_amt;
   assign DELAY_LOOP_POWERDOWN_OUT = q.loop_pd;
   assign DIGITAL_CLOCK_POWERDOWN_OUT = q.loop_pd;
   assign FINE_LINE_DUTY_CORRECT_EN_OUT = q.fine_dc;
   assign FINE_LINE_CROSS_CTRL_EN_OUT = q.fine_xc;
   assign COARSE_LINE_DUTY_CORRECT_EN_OUT = q.coarse_dc;
   assign COARSE_LINE_CROSS_CTRL_EN_OUT = q.coarse_xc;
   assign DELAY_CODE_OUT = q.code;
   assign LOOP_LOCK_FLAG_OUT = q.lock;

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   sequence s_write(logic [7:0] idx);
      commit && q.awaddr[9:2] == idx && q.awaddr[ADDR_W-1:10] == '0 && q.wlane0;
   endsequence
   AST_REF_PD: assert property (s_write(IDX_REF_PD) |-> ##2
      SYNTH_REF_INPUT_POWERDOWN_OUT == $past(q.wdata[BIT_REF_PD], 2))
      else $error("reference power-down not applied");
   AST_HYS_GATE: assert property (!HYSTERESIS_ENABLE_OUT |-> HYSTERESIS_AMOUNT_OUT == 10'h000)
      else $error("hysteresis applied while disabled");
   AST_RISE: assert property (s_write(IDX_SYSREF_HI) |-> ##2
      RISING_EDGE_SELECT_OUT == $past(q.wdata[BIT_RISE], 2))
      else $error("edge select not applied");
   AST_HYS_CODE: assert property (s_write(IDX_SYSREF_LO) ##1 q.hys_en[*2]
      |-> HYSTERESIS_AMOUNT_OUT[7:0] == $past(q.wdata[7:0], 2))
      else $error("hysteresis code wrong");
   AST_LOOP_PD: assert property (q.delay_loop_power[BIT_LOOP_PD] |=> DELAY_LOOP_POWERDOWN_OUT
      && DIGITAL_CLOCK_POWERDOWN_OUT && DELAY_CODE_OUT == STATIC_CODE)
      else $error("loop not held off");
   AST_DUTY: assert property (s_write(IDX_LOOP_PWR) |-> ##2
      FINE_LINE_DUTY_CORRECT_EN_OUT == $past(q.wdata[BIT_FINE_DC], 2)
      && COARSE_LINE_DUTY_CORRECT_EN_OUT == $past(q.wdata[BIT_COARSE_DC], 2))
      else $error("duty correction enables wrong");
   AST_CROSS: assert property (s_write(IDX_LOOP_PWR) |-> ##2
      FINE_LINE_CROSS_CTRL_EN_OUT == $past(q.wdata[BIT_FINE_XC], 2)
      && COARSE_LINE_CROSS_CTRL_EN_OUT == $past(q.wdata[BIT_COARSE_XC], 2))
      else $error("cross control enables wrong");
   AST_STATIC: assert property (!q.delay_loop_control[BIT_CTRL_EN] |=>
      DELAY_CODE_OUT == STATIC_CODE) else $error("static setting not held");
   AST_LOST: assert property (lp.lost_evt |=> q.lost ##1 !LOOP_LOCK_FLAG_OUT)
      else $error("loss not recorded");
   AST_BRESP: assert property (commit |=> AXI_BVALID_OUT && !AXI_AWREADY_OUT
      && !AXI_WREADY_OUT) else $error("write answer missing");
endmodule : cdl_top
